// *** core/lad_pkg.sv ***
// Package for the logic/absolute/add datapath slice: register map, field
// layout, reset values, operand selector codes and carrier types.
// Assumes one core clock with synchronous active-high reset.
//
// Summary of operation
// - OR combines source and destination bitwise and writes the destination.
// - Word results into an address register clear its top 8 bits.
// - Word source from an address register uses its low 16 bits.
// - OR sets sign and zero from result; overflow and carry stay.
// - Byte OR into address register zero-expands source; byte areg source gives 8 bits.
// - Magnitude replaces the byte or word destination with its absolute value.
// - Magnitude sets overflow only for the most negative value of the size.
// - Magnitude leaves carry undefined; sign and zero follow the result.
// - Carry increment adds the carry flag into the destination.
// - Carry increment sets overflow on signed range exit, else clears.
// - Carry increment sets carry on unsigned range exit, else clears.
// - Byte add into address register is a 16-bit add, top 8 bits cleared.
// - Byte add from an address register uses its low 8 bits.
// - Long add into areg zero-extends; flags from 32 bits, store 24 bits.
// - Long add into stack pointer sign-extends source; store low 24 bits.
// - Register names map by size: low or high byte of r0/r1, 16-bit register, register pair.
// - Add sets overflow on signed range exit of the size, else clears.
`default_nettype none
package lad_pkg;

    // Register map, byte addresses
    localparam logic [7:0] LAD_REG_CTRL   = 8'h00;
    localparam logic [7:0] LAD_REG_SRC    = 8'h04;
    localparam logic [7:0] LAD_REG_MEM    = 8'h08;
    localparam logic [7:0] LAD_REG_FLAGS  = 8'h0C;
    localparam logic [7:0] LAD_REG_STATUS = 8'h10;
    localparam logic [7:0] LAD_REG_RESULT = 8'h14;
    localparam logic [7:0] LAD_REG_R0     = 8'h20;
    localparam logic [7:0] LAD_REG_R1     = 8'h24;
    localparam logic [7:0] LAD_REG_R2     = 8'h28;
    localparam logic [7:0] LAD_REG_R3     = 8'h2C;
    localparam logic [7:0] LAD_REG_AR0    = 8'h30;
    localparam logic [7:0] LAD_REG_AR1    = 8'h34;
    localparam logic [7:0] LAD_REG_SP     = 8'h38;

    // Control word fields
    localparam int LAD_CTRL_OP_LSB   = 0;
    localparam int LAD_CTRL_SIZE_LSB = 2;
    localparam int LAD_CTRL_DST_LSB  = 4;
    localparam int LAD_CTRL_SRC_LSB  = 8;
    localparam int LAD_CTRL_GO_BIT   = 31;

    // Flag and status bit positions
    localparam int LAD_FLAG_C   = 0;
    localparam int LAD_FLAG_Z   = 1;
    localparam int LAD_FLAG_S   = 2;
    localparam int LAD_FLAG_O   = 3;
    localparam int LAD_ST_BUSY  = 0;
    localparam int LAD_ST_ERROR = 1;

    // Widths of the core registers
    localparam int LAD_DATA_W = 16;
    localparam int LAD_ADDR_W = 24;

    // Reset values
    localparam logic [15:0] LAD_RST_DATA = 16'h0000;
    localparam logic [23:0] LAD_RST_ADDR = 24'h000000;
    localparam logic [31:0] LAD_RST_WORD = 32'h00000000;

    typedef enum logic [1:0] {
        LAD_OP_OR   = 2'h0,
        LAD_OP_ABS  = 2'h1,
        LAD_OP_CINC = 2'h2,
        LAD_OP_ADD  = 2'h3
    } lad_op_t;

    typedef enum logic [1:0] {
        LAD_SZ_B = 2'h0,
        LAD_SZ_W = 2'h1,
        LAD_SZ_L = 2'h2,
        LAD_SZ_X = 2'h3
    } lad_size_t;

    // Operand selectors; codes 0..3 are the data register slots
    typedef enum logic [3:0] {
        LAD_SEL_D0  = 4'h0,
        LAD_SEL_D1  = 4'h1,
        LAD_SEL_D2  = 4'h2,
        LAD_SEL_D3  = 4'h3,
        LAD_SEL_AR0 = 4'h4,
        LAD_SEL_AR1 = 4'h5,
        LAD_SEL_MEM = 4'h6,
        LAD_SEL_IMM = 4'h7,
        LAD_SEL_SP  = 4'h8
    } lad_sel_t;

    typedef struct packed {
        lad_sel_t  src;
        lad_sel_t  dst;
        lad_size_t size;
        lad_op_t   op;
    } lad_cmd_t;

    typedef struct packed {
        logic o;
        logic s;
        logic z;
        logic c;
    } lad_flags_t;

    typedef enum logic [1:0] {
        LAD_ST_IDLE = 2'b01,
        LAD_ST_EXEC = 2'b10
    } lad_state_t;

endpackage : lad_pkg
`default_nettype wire

// *** core/lad_alu.sv ***
// Combinational arithmetic/logic unit of the datapath slice.
// Assumes operands already sized and extended by the caller.
`timescale 1ns/1ns
`default_nettype none
module lad_alu (
    // Command
    input  wire lad_pkg::lad_op_t    op,
    input  wire lad_pkg::lad_size_t  size,
    // Operands
    input  wire logic [31:0]         dst_val,
    input  wire logic [31:0]         src_val,
    input  wire lad_pkg::lad_flags_t flags_in,
    // Results
    output logic [31:0]              result,
    output lad_pkg::lad_flags_t      flags_out
);
    import lad_pkg::*;

    // Top bit of the selected size
    function automatic logic top_bit(input lad_size_t sz, input logic [31:0] v);
        unique case (sz)
            LAD_SZ_B: top_bit = v[7];
            LAD_SZ_W: top_bit = v[15];
            default:  top_bit = v[31];
        endcase
    endfunction : top_bit

    // Keeps only the bits of the selected size
    function automatic logic [31:0] size_mask(input lad_size_t sz, input logic [31:0] v);
        unique case (sz)
            LAD_SZ_B: size_mask = {24'h000000, v[7:0]};
            LAD_SZ_W: size_mask = {16'h0000, v[15:0]};
            default:  size_mask = v;
        endcase
    endfunction : size_mask

    // Carry out just above the selected size
    function automatic logic carry_out(input lad_size_t sz, input logic [32:0] s);
        unique case (sz)
            LAD_SZ_B: carry_out = s[8];
            LAD_SZ_W: carry_out = s[16];
            default:  carry_out = s[32];
        endcase
    endfunction : carry_out

    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] sum;
    logic [31:0] neg;
    logic [31:0] min_val;

    assign a       = size_mask(size, dst_val);
    assign min_val = (size == LAD_SZ_B) ? 32'h00000080 : (size == LAD_SZ_W) ? 32'h00008000 : 32'h80000000;

    // Result and flag selection per operation
    always_comb begin
        b         = size_mask(size, src_val);
        neg       = 32'h00000000;
        sum       = 33'h000000000;
        result    = 32'h00000000;
        flags_out = flags_in;
        unique case (op)
            LAD_OP_OR: begin
                result = a | b;
            end
            LAD_OP_ABS: begin
                neg         = size_mask(size, 32'h00000000 - a);
                result      = top_bit(size, a) ? neg : a;
                flags_out.o = (a == min_val);
            end
            LAD_OP_CINC: begin
                b           = {31'h00000000, flags_in.c};
                sum         = {1'b0, a} + {1'b0, b};
                result      = size_mask(size, sum[31:0]);
                flags_out.c = carry_out(size, sum);
                flags_out.o = (top_bit(size, a) == top_bit(size, b)) &&
                              (top_bit(size, result) != top_bit(size, a));
            end
            LAD_OP_ADD: begin
                sum         = {1'b0, a} + {1'b0, b};
                result      = size_mask(size, sum[31:0]);
                flags_out.c = carry_out(size, sum);
                flags_out.o = (top_bit(size, a) == top_bit(size, b)) &&
                              (top_bit(size, result) != top_bit(size, a));
            end
        endcase
        // Sign and zero always follow the full operation width
        flags_out.s = top_bit(size, result);
        flags_out.z = (result == 32'h00000000);
    end

endmodule : lad_alu
`default_nettype wire

// *** core/lad_datapath.sv ***
// Datapath slice top: register file, flags, command decode and write-back.
// Assumes a decoder that loads operands and commands over the plain
// register port and reads results back one cycle after a read strobe.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module lad_datapath (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          srst,
    // Register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    // Memory write-back of indirect destinations
    output logic [31:0]        mem_wdata,
    output lad_pkg::lad_size_t mem_wsize,
    output logic               mem_we,
    // Status
    output lad_pkg::lad_flags_t flags,
    output logic               busy,
    output logic               cmd_error
);
    import lad_pkg::*;

    // Core registers
    logic [15:0] r0;
    logic [15:0] r1;
    logic [15:0] r2;
    logic [15:0] r3;
    logic [23:0] ar0;
    logic [23:0] ar1;
    logic [23:0] sp;
    logic [31:0] src_word;
    logic [31:0] mem_word;
    logic [31:0] result_word;
    lad_cmd_t    cmd;
    lad_state_t  state;

    // Decoded operands
    lad_cmd_t    wr_cmd;
    lad_size_t   eff_size;
    logic        dst_areg;
    logic        src_areg;
    logic [31:0] dst_val;
    logic [31:0] src_val;
    logic [31:0] alu_res;
    lad_flags_t  alu_flags;
    logic        go_write;
    logic        exec;
    logic        err_clear;

    assign wr_cmd    = lad_cmd_t'(reg_wdata[11:0]);
    assign go_write  = reg_wr && (reg_addr == LAD_REG_CTRL) && reg_wdata[LAD_CTRL_GO_BIT];
    assign exec      = (state == LAD_ST_EXEC);
    assign err_clear = reg_wr && (reg_addr == LAD_REG_STATUS) && reg_wdata[LAD_ST_ERROR];
    assign dst_areg  = (cmd.dst == LAD_SEL_AR0) || (cmd.dst == LAD_SEL_AR1);
    assign src_areg  = (cmd.src == LAD_SEL_AR0) || (cmd.src == LAD_SEL_AR1);

    // Reads a data register slot at the given size
    function automatic logic [31:0] data_slot(input lad_sel_t sel, input lad_size_t sz,
                                              input logic [15:0] d0, input logic [15:0] d1,
                                              input logic [15:0] d2, input logic [15:0] d3);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (sz)
            LAD_SZ_B: begin
                // Byte slots: low and high halves of the first two registers
                unique case (sel)
                    LAD_SEL_D0: v = {24'h000000, d0[7:0]};
                    LAD_SEL_D1: v = {24'h000000, d0[15:8]};
                    LAD_SEL_D2: v = {24'h000000, d1[7:0]};
                    default:    v = {24'h000000, d1[15:8]};
                endcase
            end
            LAD_SZ_W: begin
                unique case (sel)
                    LAD_SEL_D0: v = {16'h0000, d0};
                    LAD_SEL_D1: v = {16'h0000, d2};
                    LAD_SEL_D2: v = {16'h0000, d1};
                    default:    v = {16'h0000, d3};
                endcase
            end
            default: begin
                // Long slots pair the upper register over the lower one
                v = (sel == LAD_SEL_D0) ? {d2, d0} : {d3, d1};
            end
        endcase
        return v;
    endfunction : data_slot

    // Reads an address register at the operand size
    function automatic logic [31:0] areg_read(input lad_size_t sz, input logic [23:0] v);
        unique case (sz)
            LAD_SZ_B: areg_read = {24'h000000, v[7:0]};
            LAD_SZ_W: areg_read = {16'h0000, v[15:0]};
            default:  areg_read = {8'h00, v};
        endcase
    endfunction : areg_read

    // Fetches any selected operand; data and address registers at the given size, stack pointer, memory and immediate words unsized
    function automatic logic [31:0] operand(input lad_sel_t sel, input lad_size_t sz,
                                            input logic [31:0] mem_v, input logic [31:0] imm_v);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (sel)
            LAD_SEL_AR0: v = areg_read(sz, ar0);
            LAD_SEL_AR1: v = areg_read(sz, ar1);
            LAD_SEL_MEM: v = mem_v;
            LAD_SEL_IMM: v = imm_v;
            LAD_SEL_SP:  v = {8'h00, sp};
            default:     v = data_slot(sel, sz, r0, r1, r2, r3);
        endcase
        return v;
    endfunction : operand

    // Rejects combinations that the decoder must never issue
    function automatic logic cmd_illegal(input lad_cmd_t c);
        logic bad;
        logic to_sp;
        to_sp = (c.dst == LAD_SEL_SP);
        bad   = (c.size == LAD_SZ_X);
        bad   = bad || (c.dst == LAD_SEL_IMM) || (c.dst > LAD_SEL_SP);
        bad   = bad || (to_sp && !(c.op == LAD_OP_ADD && c.size == LAD_SZ_L && c.src == LAD_SEL_IMM));
        bad   = bad || (c.size == LAD_SZ_L && c.op != LAD_OP_ADD);
        bad   = bad || (c.size == LAD_SZ_L && (c.dst == LAD_SEL_D1 || c.dst == LAD_SEL_D3));
        if (c.op == LAD_OP_OR || c.op == LAD_OP_ADD) begin
            bad = bad || (c.src == LAD_SEL_SP) || (c.src > LAD_SEL_SP);
            bad = bad || (c.size == LAD_SZ_L && (c.src == LAD_SEL_D1 || c.src == LAD_SEL_D3));
            // Byte size may not pair address registers on both sides
            bad = bad || (c.size == LAD_SZ_B && (c.src == LAD_SEL_AR0 || c.src == LAD_SEL_AR1) &&
                          (c.dst == LAD_SEL_AR0 || c.dst == LAD_SEL_AR1));
        end
        return bad;
    endfunction : cmd_illegal

    // Byte work into an address register widens to a 16-bit operation
    always_comb begin
        eff_size = cmd.size;
        if (cmd.size == LAD_SZ_B && dst_areg) begin
            eff_size = LAD_SZ_W;
        end
    end

    // Operand preparation; source zero-expansion comes from the byte read
    always_comb begin
        // A byte op on an address register works on its low 16 bits, not 8
        dst_val = operand(cmd.dst, eff_size, mem_word, src_word);
        src_val = operand(cmd.src, cmd.size, mem_word, src_word);
        if (cmd.dst == LAD_SEL_SP) begin
            // Stack pointer adds take a signed 16-bit immediate
            src_val = {{16{src_word[15]}}, src_word[15:0]};
        end else if (cmd.src == LAD_SEL_IMM || cmd.src == LAD_SEL_MEM) begin
            unique case (cmd.size)
                LAD_SZ_B: src_val = {24'h000000, src_val[7:0]};
                LAD_SZ_W: src_val = {16'h0000, src_val[15:0]};
                default:  src_val = src_val;
            endcase
        end
        if (cmd.dst == LAD_SEL_MEM) begin
            unique case (cmd.size)
                LAD_SZ_B: dst_val = {24'h000000, mem_word[7:0]};
                LAD_SZ_W: dst_val = {16'h0000, mem_word[15:0]};
                default:  dst_val = mem_word;
            endcase
        end
        if (src_areg && cmd.size == LAD_SZ_B) begin
            src_val = {24'h000000, src_val[7:0]};
        end
    end

    lad_alu u_alu (
        .op        (cmd.op),
        .size      (eff_size),
        .dst_val   (dst_val),
        .src_val   (src_val),
        .flags_in  (flags),
        .result    (alu_res),
        .flags_out (alu_flags)
    );

    // Sequencer: a go write is taken only while idle, exec lasts one cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= LAD_ST_IDLE;
            cmd   <= lad_cmd_t'(12'h000);
        end else begin
            unique case (state)
                LAD_ST_IDLE: begin
                    if (go_write && !cmd_illegal(wr_cmd)) begin
                        cmd   <= wr_cmd;
                        state <= LAD_ST_EXEC;
                    end
                end
                LAD_ST_EXEC: begin
                    state <= LAD_ST_IDLE;
                end
            endcase
        end
    end

    // Busy mirrors the sequencer so the output comes from a flip-flop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state == LAD_ST_IDLE) && go_write && !cmd_illegal(wr_cmd);
        end
    end

    // Sticky error: a new refusal in the clearing cycle wins over the clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_error <= 1'b0;
        end else if (go_write && (exec || cmd_illegal(wr_cmd))) begin
            cmd_error <= 1'b1;
        end else if (err_clear) begin
            cmd_error <= 1'b0;
        end
    end

    // Operand holding registers loaded by port writes to the source and memory offsets
    always_ff @(posedge core_clk) begin
        if (srst) begin
            src_word <= LAD_RST_WORD;
            mem_word <= LAD_RST_WORD;
        end else if (reg_wr) begin
            if (reg_addr == LAD_REG_SRC) begin
                src_word <= reg_wdata;
            end
            if (reg_addr == LAD_REG_MEM) begin
                mem_word <= reg_wdata;
            end
        end
    end

    // Data registers; execution write-back wins over a port write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            r0 <= LAD_RST_DATA;
            r1 <= LAD_RST_DATA;
            r2 <= LAD_RST_DATA;
            r3 <= LAD_RST_DATA;
        end else if (exec && cmd.dst <= LAD_SEL_D3) begin
            unique case (cmd.size)
                LAD_SZ_B: begin
                    unique case (cmd.dst)
                        LAD_SEL_D0: r0[7:0]  <= alu_res[7:0];
                        LAD_SEL_D1: r0[15:8] <= alu_res[7:0];
                        LAD_SEL_D2: r1[7:0]  <= alu_res[7:0];
                        default:    r1[15:8] <= alu_res[7:0];
                    endcase
                end
                LAD_SZ_W: begin
                    unique case (cmd.dst)
                        LAD_SEL_D0: r0 <= alu_res[15:0];
                        LAD_SEL_D1: r2 <= alu_res[15:0];
                        LAD_SEL_D2: r1 <= alu_res[15:0];
                        default:    r3 <= alu_res[15:0];
                    endcase
                end
                default: begin
                    if (cmd.dst == LAD_SEL_D0) begin
                        {r2, r0} <= alu_res;
                    end else begin
                        {r3, r1} <= alu_res;
                    end
                end
            endcase
        end else if (reg_wr) begin
            if (reg_addr == LAD_REG_R0) r0 <= reg_wdata[15:0];
            if (reg_addr == LAD_REG_R1) r1 <= reg_wdata[15:0];
            if (reg_addr == LAD_REG_R2) r2 <= reg_wdata[15:0];
            if (reg_addr == LAD_REG_R3) r3 <= reg_wdata[15:0];
        end
    end

    // Address registers and stack pointer hold 24 bits
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ar0 <= LAD_RST_ADDR;
            ar1 <= LAD_RST_ADDR;
            sp  <= LAD_RST_ADDR;
        end else if (exec && (dst_areg || cmd.dst == LAD_SEL_SP)) begin
            if (cmd.dst == LAD_SEL_AR0) begin
                // Narrow results clear the top byte, long keeps 24 bits
                ar0 <= (eff_size == LAD_SZ_L) ? alu_res[23:0] : {8'h00, alu_res[15:0]};
            end else if (cmd.dst == LAD_SEL_AR1) begin
                ar1 <= (eff_size == LAD_SZ_L) ? alu_res[23:0] : {8'h00, alu_res[15:0]};
            end else begin
                sp <= alu_res[23:0];
            end
        end else if (reg_wr) begin
            if (reg_addr == LAD_REG_AR0) ar0 <= reg_wdata[23:0];
            if (reg_addr == LAD_REG_AR1) ar1 <= reg_wdata[23:0];
            if (reg_addr == LAD_REG_SP) sp <= reg_wdata[23:0];
        end
    end

    // Flags; carry is left as it was after magnitude, an allowed choice
    always_ff @(posedge core_clk) begin
        if (srst) begin
            flags <= lad_flags_t'(4'h0);
        end else if (exec) begin
            flags.s <= alu_flags.s;
            flags.z <= alu_flags.z;
            if (cmd.op != LAD_OP_OR) begin
                flags.o <= alu_flags.o;
            end
            if (cmd.op == LAD_OP_CINC || cmd.op == LAD_OP_ADD) begin
                flags.c <= alu_flags.c;
            end
        end else if (reg_wr && reg_addr == LAD_REG_FLAGS) begin
            flags <= lad_flags_t'(reg_wdata[3:0]);
        end
    end

    // Result word and memory write-back pulse for indirect destinations
    always_ff @(posedge core_clk) begin
        if (srst) begin
            result_word <= LAD_RST_WORD;
            mem_wdata   <= LAD_RST_WORD;
            mem_wsize   <= LAD_SZ_B;
            mem_we      <= 1'b0;
        end else begin
            mem_we <= exec && (cmd.dst == LAD_SEL_MEM);
            if (exec) begin
                result_word <= alu_res;
                mem_wdata   <= alu_res;
                mem_wsize   <= cmd.size;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= LAD_RST_WORD;
        end else if (reg_rd) begin
            unique case (reg_addr)
                LAD_REG_CTRL:   reg_rdata <= {20'h00000, cmd};
                LAD_REG_SRC:    reg_rdata <= src_word;
                LAD_REG_MEM:    reg_rdata <= mem_word;
                LAD_REG_FLAGS:  reg_rdata <= {28'h0000000, flags};
                LAD_REG_STATUS: reg_rdata <= {30'h00000000, cmd_error, busy};
                LAD_REG_RESULT: reg_rdata <= result_word;
                LAD_REG_R0:     reg_rdata <= {16'h0000, r0};
                LAD_REG_R1:     reg_rdata <= {16'h0000, r1};
                LAD_REG_R2:     reg_rdata <= {16'h0000, r2};
                LAD_REG_R3:     reg_rdata <= {16'h0000, r3};
                LAD_REG_AR0:    reg_rdata <= {8'h00, ar0};
                LAD_REG_AR1:    reg_rdata <= {8'h00, ar1};
                LAD_REG_SP:     reg_rdata <= {8'h00, sp};
                default:        reg_rdata <= LAD_RST_WORD;
            endcase
        end else begin
            reg_rdata <= LAD_RST_WORD;
        end
    end

endmodule : lad_datapath
`default_nettype wire

// *** sim/lad_datapath_props.sv ***
// Port checks of the datapath slice.
// Assumes a bind onto lad_datapath.
`timescale 1ns/1ns
`default_nettype none
module lad_datapath_props (
    // Watched ports
    input wire logic core_clk, srst, reg_wr, reg_rd, mem_we, busy, cmd_error,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata, reg_rdata,
    input wire lad_pkg::lad_flags_t flags
);
    import lad_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    wire go = reg_wr && reg_addr == LAD_REG_CTRL && reg_wdata[31]; // Command start
    property p_b1; busy |=> !busy; endproperty
    a_b1: assert property (p_b1) else $error("busy long");
    property p_b2; busy |-> $past(go); endproperty
    a_b2: assert property (p_b2) else $error("busy alone");
    property p_e1; go && reg_wdata[3:2] == 2'h3 |=> cmd_error; endproperty
    a_e1: assert property (p_e1) else $error("size taken");
    property p_e2; $rose(cmd_error) |-> $past(go); endproperty
    a_e2: assert property (p_e2) else $error("error alone");
    property p_r; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_r: assert property (p_r) else $error("stray data");
    property p_f; !busy && !reg_wr |=> $stable(flags); endproperty
    a_f: assert property (p_f) else $error("flags moved");
    property p_m1; mem_we |=> !mem_we; endproperty
    a_m1: assert property (p_m1) else $error("mem long");
    property p_m2; mem_we |-> $past(busy); endproperty
    a_m2: assert property (p_m2) else $error("mem alone");
    c_b: cover property (busy);
    c_m: cover property (mem_we);
    c_e: cover property (cmd_error);
endmodule : lad_datapath_props
`default_nettype wire

// *** sim/lad_mem_sink.sv ***
// Memory side model.
// Assumes one-cycle mem_we.
`timescale 1ns/1ns
`default_nettype none
module lad_mem_sink (
    // Write-back in, word out
    input wire logic core_clk, mem_we,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] last_word
);
    // Fed by indirect destinations only
    always_ff @(posedge core_clk) if (mem_we) last_word <= mem_wdata;
endmodule : lad_mem_sink
`default_nettype wire

// *** sim/logic_abs_add_datapath_tb_top.sv ***
// Bench top of the datapath slice.
// Assumes all other files compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module logic_abs_add_datapath_tb_top;
    import lad_pkg::*;
    logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, mem_we, busy, cmd_error;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_wdata, last_word;
    lad_size_t mem_wsize;
    lad_flags_t flags;
    int errors = 0, check_count = 0;
    lad_datapath i_dut (.*);
    lad_mem_sink i_mem (.*);
    // Clock and watchdog
    initial forever #4 core_clk = ~core_clk;
    initial begin #9000; errors++; end_sim(); end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk) reg_wr <= 0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_rd <= 1; reg_addr <= a;
        @(posedge core_clk) reg_rd <= 0;
        #1 `CHK("read", e, reg_rdata)
        @(posedge core_clk);
    endtask : rd
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // Tests
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 0;
        wr(8'h0C, 9); wr(8'h30, 32'h128001); wr(8'h20, 32'h100); wr(0, 32'h80000404);
        rd(8'h20, 32'h8101); rd(8'h0C, 32'hD);
        wr(8'h08, 32'h80); wr(0, 32'h80000061); #1 `CHK("flags", 4'hC, flags & 4'hE)
        @(posedge core_clk) #1 `CHK("mem", 32'h80, last_word)
        @(posedge core_clk) $display("test 1 done");
        wr(8'h0C, 1); wr(8'h20, 32'h7FFF); wr(0, 32'h80000006); rd(8'h0C, 32'hC);
        wr(8'h38, 32'h10); wr(8'h04, 32'hFFF0); wr(0, 32'h8000078B); rd(8'h38, 0); rd(8'h0C, 3);
        $display("test 2 done");
        wr(0, 32'h8000000C); rd(8'h10, 2); wr(8'h10, 2); rd(8'h10, 0); rd(8'hFC, 0);
        $display("test 3 done");
        wr(8'h34, 32'hAB12F0); wr(8'h04, 32'h20); wr(0, 32'h80000753); rd(8'h34, 32'h1310); rd(8'h0C, 0);
        wr(8'h30, 32'hFF1234); wr(0, 32'h80000046); rd(8'h30, 32'h1234);
        wr(8'h08, 32'hFF00); wr(0, 32'h80000065); #1 `CHK("wsize", LAD_SZ_W, mem_wsize)
        @(posedge core_clk) #1 `CHK("mem", 32'h100, last_word)
        $display("test 4 done");
        end_sim();
    end
endmodule : logic_abs_add_datapath_tb_top
bind lad_datapath lad_datapath_props i_props (.*);
`default_nettype wire
